/* File: hdl/psdr_status_bank.sv */
/*
  Per-port status and discovery result register bank, four ports,
  Avalon-MM slave with one wait state, sticky event status and
  one level interrupt.
  Assumes all port inputs are synchronous to mclk.
*/
`timescale 1ns/1ns
`default_nettype none

module psdr_status_bank
  import psdr_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Avalon-MM slave
  input wire logic [PSDR_AW-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [PSDR_DW-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [PSDR_DW-1:0] avs_readdata,
  output logic avs_waitrequest,
  // Port logic
  input wire psdr_port_in_s port_in [PSDR_NPORT],
  // Interrupt
  output logic irq
);

  // ==========================================================
  // Declarations
  psdr_port_view_s view [PSDR_NPORT];
  logic [PSDR_NPORT-1:0] evt_done;
  logic [PSDR_NPORT-1:0] evt_meas;
  logic [PSDR_IRQ_W-1:0] events;

  logic waitrequest_ff;
  logic [PSDR_DW-1:0] readdata_ff;
  logic [PSDR_DW-1:0] nxt_rdata;
  logic [PSDR_IRQ_W-1:0] irq_stat_ff;
  logic [PSDR_IRQ_W-1:0] irq_mask_ff;
  logic [PSDR_IRQ_W-1:0] nxt_stat;
  logic irq_ff;

  logic req;
  logic accept;
  logic glob_sel;
  logic [ADDR_PORT_MSB-ADDR_PORT_LSB:0] port_sel;
  logic [ADDR_IDX_MSB-ADDR_IDX_LSB:0] idx;
  logic stat_rd_clr;
  logic mask_wr;

  psdr_stat1_s cur_stat1;
  psdr_stat2_s cur_stat2;
  logic cur_meas;
  logic [PSDR_ADC_W-1:0] cur_result;

  // ==========================================================
  // Per-port trackers
  for (genvar p = 0; p < PSDR_NPORT; p++) begin : g_port
    psdr_port_track u_track (
      .mclk(mclk),
      .srst(srst),
      .port_in(port_in[p]),
      .view(view[p]),
      .done_evt(evt_done[p]),
      .meas_evt(evt_meas[p])
    );
  end

  assign events = {evt_meas, evt_done};

  // ==========================================================
  // Address decode
  assign req = avs_read | avs_write;
  assign accept = req & ~waitrequest_ff;
  assign glob_sel = avs_address[ADDR_GLOB_BIT];
  assign port_sel = avs_address[ADDR_PORT_MSB:ADDR_PORT_LSB];
  assign idx = avs_address[ADDR_IDX_MSB:ADDR_IDX_LSB];

  assign cur_stat1 = view[port_sel].stat1;
  assign cur_stat2 = view[port_sel].stat2;
  assign cur_meas = view[port_sel].meas_done;
  assign cur_result = view[port_sel].result;

  // Only the mask register accepts data; port registers drop writes
  assign mask_wr = accept && avs_write && glob_sel &&
                   idx == IDX_IRQ_MASK && avs_byteenable[0];
  assign stat_rd_clr = accept && avs_read && glob_sel &&
                       idx == IDX_IRQ_STAT;

  // ==========================================================
  // Read multiplexer; unmapped addresses read as zero
  always_comb begin
    nxt_rdata = RDATA_RST;
    if (glob_sel) begin
      case (idx)
        IDX_IRQ_STAT: nxt_rdata[PSDR_IRQ_W-1:0] = irq_stat_ff;
        IDX_IRQ_MASK: nxt_rdata[PSDR_IRQ_W-1:0] = irq_mask_ff;
        default: nxt_rdata = RDATA_RST;
      endcase
    end else begin
      case (idx)
        IDX_STAT1: nxt_rdata[PSDR_REG_W-1:0] = cur_stat1;
        IDX_STAT2: nxt_rdata[PSDR_REG_W-1:0] = cur_stat2;
        IDX_DLOW: nxt_rdata[PSDR_REG_W-1:0] = cur_result[PSDR_REG_W-1:0];
        IDX_DHIGH: begin
          nxt_rdata[PSDR_REG_W-1:0] =
            {cur_meas, cur_result[PSDR_ADC_W-1:PSDR_REG_W]};
        end
        default: nxt_rdata = RDATA_RST;
      endcase
    end
  end

  // ==========================================================
  // Bus handshake: one wait state, data launched with waitrequest low
  always_ff @(posedge mclk) begin
    if (srst) waitrequest_ff <= 1'b1;
    else waitrequest_ff <= ~(req & waitrequest_ff);
  end

  always_ff @(posedge mclk) begin
    if (srst) readdata_ff <= RDATA_RST;
    else if (avs_read && waitrequest_ff) readdata_ff <= nxt_rdata;
  end

  assign avs_waitrequest = waitrequest_ff;
  assign avs_readdata = readdata_ff;

  // ==========================================================
  // Interrupt mask
  always_ff @(posedge mclk) begin
    if (srst) irq_mask_ff <= IRQ_RST;
    else if (mask_wr) irq_mask_ff <= avs_writedata[PSDR_IRQ_W-1:0];
  end

  // ==========================================================
  // Sticky event status
  // A read clears only the bits it returned, so an event that lands
  // between launch and accept survives; a new event beats the clear.
  always_comb begin
    nxt_stat = irq_stat_ff;
    if (stat_rd_clr) nxt_stat = nxt_stat & ~readdata_ff[PSDR_IRQ_W-1:0];
    nxt_stat = nxt_stat | events;
  end

  always_ff @(posedge mclk) begin
    if (srst) irq_stat_ff <= IRQ_RST;
    else irq_stat_ff <= nxt_stat;
  end

  // ==========================================================
  // Interrupt output, one cycle behind the status
  always_ff @(posedge mclk) begin
    if (srst) irq_ff <= 1'b0;
    else irq_ff <= |(irq_stat_ff & irq_mask_ff);
  end

  assign irq = irq_ff;

  // ==========================================================
  // Checks
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (srst);

  a_wait_one_state: assert property (
    (req && waitrequest_ff) |=> !waitrequest_ff ##1 waitrequest_ff)
    else $error("waitrequest not low for exactly one cycle");

  a_stat1_layout: assert property (
    (avs_read && waitrequest_ff && !glob_sel && idx == IDX_STAT1)
    |=> readdata_ff[PSDR_REG_W-1:0] == $past(cur_stat1))
    else $error("status one read data wrong");

  a_stat2_layout: assert property (
    (avs_read && waitrequest_ff && !glob_sel && idx == IDX_STAT2)
    |=> readdata_ff[PSDR_REG_W-1:0] == $past(cur_stat2)
        && readdata_ff[PSDR_DW-1:PSDR_REG_W-3] == '0)
    else $error("status two read data wrong");

  a_dlow_result: assert property (
    (avs_read && waitrequest_ff && !glob_sel && idx == IDX_DLOW)
    |=> readdata_ff[PSDR_REG_W-1:0] == $past(cur_result[PSDR_REG_W-1:0]))
    else $error("discovery low byte wrong");

  a_dhigh_result: assert property (
    (avs_read && waitrequest_ff && !glob_sel && idx == IDX_DHIGH)
    |=> readdata_ff[PSDR_REG_W-2:0] == $past(cur_result[PSDR_ADC_W-1:PSDR_REG_W])
        && readdata_ff[PSDR_REG_W-1] == $past(cur_meas))
    else $error("discovery high byte wrong");

  a_write_ignored: assert property (
    (accept && avs_write && !glob_sel) |=> $stable(irq_mask_ff))
    else $error("write to port register changed state");

  a_read_no_side: assert property (
    (accept && avs_read && !glob_sel)
    |=> (irq_stat_ff & $past(irq_stat_ff)) == $past(irq_stat_ff))
    else $error("port register read cleared status");

  a_irq_follow: assert property (
    |(irq_stat_ff & irq_mask_ff) |=> irq_ff)
    else $error("interrupt not raised for unmasked status");

  a_irq_quiet: assert property (
    !(|(irq_stat_ff & irq_mask_ff)) |=> !irq_ff)
    else $error("interrupt raised with no unmasked status");

  a_event_sticky: assert property (
    (|events) |=> (irq_stat_ff & $past(events)) == $past(events))
    else $error("event lost in status register");

  // ==========================================================
  // Bus and interrupt register checks
  a_wait_idle: assert property (
    !req |=> waitrequest_ff)
    else $error("waitrequest low without a request");

  a_accept_once: assert property (
    accept |=> !accept)
    else $error("request accepted on two edges in a row");

  a_rdata_hold: assert property (
    !(avs_read && waitrequest_ff) |=> $stable(readdata_ff))
    else $error("read data changed outside a read launch");

  a_rdata_upper: assert property (
    (avs_read && waitrequest_ff) |=> readdata_ff[PSDR_DW-1:PSDR_REG_W] == '0)
    else $error("read data above the register width not zero");

  a_port_unmapped: assert property (
    (avs_read && waitrequest_ff && !glob_sel && (idx < IDX_STAT1 || idx > IDX_DHIGH))
    |=> readdata_ff == RDATA_RST)
    else $error("unmapped port register read not zero");

  a_glob_unmapped: assert property (
    (avs_read && waitrequest_ff && glob_sel && idx > IDX_IRQ_MASK)
    |=> readdata_ff == RDATA_RST)
    else $error("unmapped global register read not zero");

  a_stat_read: assert property (
    (avs_read && waitrequest_ff && glob_sel && idx == IDX_IRQ_STAT)
    |=> readdata_ff[PSDR_IRQ_W-1:0] == $past(irq_stat_ff))
    else $error("interrupt status read data wrong");

  a_mask_read: assert property (
    (avs_read && waitrequest_ff && glob_sel && idx == IDX_IRQ_MASK)
    |=> readdata_ff[PSDR_IRQ_W-1:0] == $past(irq_mask_ff))
    else $error("interrupt mask read data wrong");

  a_mask_write: assert property (
    mask_wr |=> irq_mask_ff == $past(avs_writedata[PSDR_IRQ_W-1:0]))
    else $error("interrupt mask write lost");

  a_mask_keep: assert property (
    !mask_wr |=> $stable(irq_mask_ff))
    else $error("interrupt mask changed without a write");

  // Only meaningful when no event lands in the clearing cycle
  a_stat_clear: assert property (
    (stat_rd_clr && !(|events))
    |=> (irq_stat_ff & $past(readdata_ff[PSDR_IRQ_W-1:0])) == '0)
    else $error("status read did not clear returned bits");

  a_stat_hold: assert property (
    (!stat_rd_clr && !(|events)) |=> $stable(irq_stat_ff))
    else $error("status changed with no event or read");

  // ==========================================================
  // Per-port field checks against the port inputs
  // Fields lag their inputs by exactly one edge
  for (genvar p = 0; p < PSDR_NPORT; p++) begin : g_chk
    a_done_set: assert property (
      port_in[p].fn_done |=> view[p].stat1.fn_done)
      else $error("done flag not set on function finish");

    a_done_keep: assert property (
      (!port_in[p].fn_done && !port_in[p].fn_wr) |=> $stable(view[p].stat1.fn_done))
      else $error("done flag changed with no port event");

    a_fail_follow: assert property (
      1'b1 |=> view[p].stat1.disc_fail == $past(port_in[p].disc_fail))
      else $error("discovery fail flag not following port");

    a_wdog_follow: assert property (
      1'b1 |=> view[p].stat2.wdog_active == $past(port_in[p].wdog_active))
      else $error("watchdog flag not following port");

    a_busy_set: assert property (
      port_in[p].adc_start |=> view[p].stat2.adc_busy)
      else $error("converter flag not set at conversion start");

    a_busy_clear: assert property (
      (port_in[p].adc_done && !port_in[p].adc_start) |=> !view[p].stat2.adc_busy)
      else $error("converter flag not cleared at conversion end");

    // Illegal codes may hold the old value, so only legal ones are checked
    a_class_take: assert property (
      (port_in[p].pwr_class <= CLASS_MAX)
      |=> view[p].stat1.pwr_class == $past(port_in[p].pwr_class))
      else $error("legal class code not shown");

    a_fault_take: assert property (
      (port_in[p].fault_code <= FAULT_MAX)
      |=> view[p].stat1.fault_code == $past(port_in[p].fault_code))
      else $error("legal fault code not shown");

    a_state_take: assert property (
      (port_in[p].fn_state <= STATE_MAX)
      |=> view[p].stat2.fn_state == $past(port_in[p].fn_state))
      else $error("legal function state not shown");

    a_unused_zero: assert property (
      view[p].stat2.unused == '0)
      else $error("unused status bits not zero");

    a_result_keep: assert property (
      !port_in[p].adc_done |=> $stable(view[p].result))
      else $error("discovery result changed without conversion end");

    a_meas_keep: assert property (
      (!port_in[p].adc_done && !port_in[p].fn_wr) |=> $stable(view[p].meas_done))
      else $error("complete flag changed with no port event");
  end

endmodule : psdr_status_bank

`default_nettype wire

/* File: hdl/psdr_pkg.sv */
/*
  Shared constants and carriers for the per-port status and discovery
  result bank of a four-port power-sourcing manager.
  Assumes word-aligned Avalon-MM byte addresses and 8-bit registers.
*/
package psdr_pkg;

  // ==========================================================
  // Sizes
  localparam int PSDR_NPORT = 4;
  localparam int PSDR_AW = 9;
  localparam int PSDR_DW = 32;
  localparam int PSDR_REG_W = 8;
  localparam int PSDR_ADC_W = 15;
  localparam int PSDR_IRQ_W = 2 * PSDR_NPORT;

  // ==========================================================
  // Address layout: byte address = port window + 4 * register index
  localparam int ADDR_IDX_LSB = 2;
  localparam int ADDR_IDX_MSB = 5;
  localparam int ADDR_PORT_LSB = 6;
  localparam int ADDR_PORT_MSB = 7;
  localparam int ADDR_GLOB_BIT = 8;

  // Register indices (select codes)
  localparam logic [3:0] IDX_STAT1 = 4'h4;
  localparam logic [3:0] IDX_STAT2 = 4'h5;
  localparam logic [3:0] IDX_DLOW = 4'h6;
  localparam logic [3:0] IDX_DHIGH = 4'h7;
  localparam logic [3:0] IDX_IRQ_STAT = 4'h0;
  localparam logic [3:0] IDX_IRQ_MASK = 4'h1;

  // ==========================================================
  // Codes and reset values
  localparam logic [3:0] FN_DISC1 = 4'h1;
  localparam logic [3:0] FN_DISC2 = 4'h2;
  localparam logic [2:0] CLASS_MAX = 3'h4;
  localparam logic [2:0] FAULT_MAX = 3'h4;
  localparam logic [2:0] STATE_MAX = 3'h5;
  localparam logic [2:0] CODE_RST = 3'h0;
  localparam logic [PSDR_IRQ_W-1:0] IRQ_RST = 8'h00;
  localparam logic [PSDR_DW-1:0] RDATA_RST = 32'h0000_0000;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic disc_fail;
    logic fn_done;
    logic [2:0] pwr_class;
    logic [2:0] fault_code;
  } psdr_stat1_s;

  typedef struct packed {
    logic [2:0] unused;
    logic wdog_active;
    logic adc_busy;
    logic [2:0] fn_state;
  } psdr_stat2_s;

  typedef struct packed {
    logic fn_wr;
    logic [3:0] fn_code;
    logic fn_done;
    logic disc_fail;
    logic [2:0] pwr_class;
    logic [2:0] fault_code;
    logic wdog_active;
    logic adc_start;
    logic adc_done;
    logic [PSDR_ADC_W-1:0] adc_result;
    logic [2:0] fn_state;
  } psdr_port_in_s;

  typedef struct packed {
    psdr_stat1_s stat1;
    psdr_stat2_s stat2;
    logic meas_done;
    logic [PSDR_ADC_W-1:0] result;
  } psdr_port_view_s;

endpackage : psdr_pkg

/* File: hdl/psdr_port_track.sv */
/*
  Per-port tracker: done flag, converter activity, discovery result
  latch and status snapshots for one port.
  Assumes port events are one-cycle pulses synchronous to mclk.
*/
`timescale 1ns/1ns
`default_nettype none

module psdr_port_track
  import psdr_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Port side
  input wire psdr_port_in_s port_in,
  // Register view and events
  output var psdr_port_view_s view,
  output logic done_evt,
  output logic meas_evt
);

  logic done_ff, busy_ff, disc_act_ff, meas_ff, wdog_ff, fail_ff;
  logic [2:0] class_ff, fault_ff, state_ff;
  logic [PSDR_ADC_W-1:0] result_ff;
  logic is_disc, conv_end, nxt_done, nxt_meas;

  assign is_disc = port_in.fn_wr &&
                   (port_in.fn_code == FN_DISC1 || port_in.fn_code == FN_DISC2);
  assign conv_end = port_in.adc_done && disc_act_ff;
  // Completion wins over a same-cycle clear so no finish is lost
  assign nxt_done = port_in.fn_done | (done_ff & ~port_in.fn_wr);
  assign nxt_meas = conv_end | (meas_ff & ~is_disc);
  assign done_evt = nxt_done & ~done_ff;
  assign meas_evt = nxt_meas & ~meas_ff;

  // ==========================================================
  // Flags
  always_ff @(posedge mclk) begin
    if (srst) begin
      done_ff <= 1'b0;
      meas_ff <= 1'b0;
      disc_act_ff <= 1'b0;
      busy_ff <= 1'b0;
    end else begin
      done_ff <= nxt_done;
      meas_ff <= nxt_meas;
      if (port_in.fn_wr) disc_act_ff <= is_disc;
      if (port_in.adc_start) busy_ff <= 1'b1;
      else if (port_in.adc_done) busy_ff <= 1'b0;
    end
  end

  // ==========================================================
  // Discovery result, captured only on a discovery conversion
  always_ff @(posedge mclk) begin
    if (srst) result_ff <= '0;
    else if (conv_end) result_ff <= port_in.adc_result;
  end

  // ==========================================================
  // Snapshots; reserved or undefined codes keep the last legal one
  always_ff @(posedge mclk) begin
    if (srst) begin
      class_ff <= CODE_RST;
      fault_ff <= CODE_RST;
      state_ff <= CODE_RST;
      fail_ff <= 1'b0;
      wdog_ff <= 1'b0;
    end else begin
      if (port_in.pwr_class <= CLASS_MAX) class_ff <= port_in.pwr_class;
      if (port_in.fault_code <= FAULT_MAX) fault_ff <= port_in.fault_code;
      if (port_in.fn_state <= STATE_MAX) state_ff <= port_in.fn_state;
      fail_ff <= port_in.disc_fail;
      wdog_ff <= port_in.wdog_active;
    end
  end

  // One driver for the whole view keeps the packed output single-sourced
  assign view = '{
    stat1: '{disc_fail: fail_ff, fn_done: done_ff, pwr_class: class_ff,
             fault_code: fault_ff},
    stat2: '{unused: CODE_RST, wdog_active: wdog_ff, adc_busy: busy_ff,
             fn_state: state_ff},
    meas_done: meas_ff,
    result: result_ff
  };

  // ==========================================================
  // Checks
  a_done_flag: assert property (@(posedge mclk) disable iff (srst)
    (port_in.fn_wr && !port_in.fn_done) |=> !done_ff)
    else $error("done flag not cleared by function write");
  a_class_range: assert property (@(posedge mclk) disable iff (srst)
    class_ff <= CLASS_MAX) else $error("class code out of range");
  a_fault_range: assert property (@(posedge mclk) disable iff (srst)
    fault_ff <= FAULT_MAX) else $error("reserved fault code shown");
  a_busy_track: assert property (@(posedge mclk) disable iff (srst)
    port_in.adc_start |=> busy_ff until port_in.adc_done)
    else $error("converter busy flag dropped early");
  a_state_range: assert property (@(posedge mclk) disable iff (srst)
    state_ff <= STATE_MAX) else $error("undefined function state shown");
  a_meas_clear: assert property (@(posedge mclk) disable iff (srst)
    (is_disc && !conv_end) |=> !meas_ff)
    else $error("measure flag not cleared at discovery start");
  a_meas_set: assert property (@(posedge mclk) disable iff (srst)
    conv_end |=> meas_ff && result_ff == $past(port_in.adc_result))
    else $error("discovery result not captured");

endmodule : psdr_port_track

`default_nettype wire

/* File: tb/psdr_host_model.sv */
/*
  Host controller model: an Avalon-MM master that reads and writes
  the per-port status bank.
  Assumes each task is entered just after a rising edge of mclk.
*/
`timescale 1ns/1ns
`default_nettype none

module psdr_host_model
  import psdr_pkg::*;
(
  // Clock
  input wire logic mclk,
  // Avalon-MM master
  output var logic [PSDR_AW-1:0] avs_address,
  output var logic avs_read,
  output var logic avs_write,
  output var logic [PSDR_DW-1:0] avs_writedata,
  output var logic [3:0] avs_byteenable,
  input wire logic [PSDR_DW-1:0] avs_readdata,
  input wire logic avs_waitrequest
);
  // ==========================================================
  // Idle bus
  initial begin
    avs_address = '0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = '0;
    avs_byteenable = 4'hF;
  end

  // ==========================================================
  // One access; the extra edge at the end keeps a following request
  // from assigning the strobe twice in one time step
  task automatic xfer(input logic [PSDR_AW-1:0] a, input logic rnw,
                      input logic [PSDR_DW-1:0] wd,
                      output logic [PSDR_DW-1:0] rd, output logic ok);
    avs_address <= a;
    avs_read <= rnw;
    avs_write <= !rnw;
    avs_writedata <= wd;
    // Request stands until the rising edge that samples waitrequest low
    do begin
      @(posedge mclk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    // Waitrequest must be back high one edge after completion
    @(posedge mclk);
    ok = (avs_waitrequest === 1'b1);
  endtask : xfer
endmodule : psdr_host_model

`default_nettype wire

/* File: tb/port_status_discovery_results_tb.sv */
/*
  Self-checking bench for the per-port status and discovery result bank.
  Assumes the host model drives the bus and this module drives port events.
*/
`timescale 1ns/1ns
`default_nettype none

module port_status_discovery_results_tb
  import psdr_pkg::*;
;
  logic mclk;
  logic srst;
  logic [PSDR_AW-1:0] address;
  logic rd_req;
  logic wr_req;
  logic [PSDR_DW-1:0] wdata;
  logic [3:0] ben;
  logic [PSDR_DW-1:0] rdata;
  logic wait_req;
  logic irq;
  psdr_port_in_s pin [PSDR_NPORT];
  int mismatches;
  int checked;

  psdr_status_bank dut_u (.mclk(mclk), .srst(srst), .avs_address(address),
    .avs_read(rd_req), .avs_write(wr_req), .avs_writedata(wdata),
    .avs_byteenable(ben), .avs_readdata(rdata), .avs_waitrequest(wait_req),
    .port_in(pin), .irq(irq));

  psdr_host_model host_u (.mclk(mclk), .avs_address(address),
    .avs_read(rd_req), .avs_write(wr_req), .avs_writedata(wdata),
    .avs_byteenable(ben), .avs_readdata(rdata), .avs_waitrequest(wait_req));

  // ==========================================================
  // Shared helpers
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask : tick

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  function automatic logic [PSDR_AW-1:0] ra(input int p, input logic [3:0] idx);
    return {1'b0, 2'(p), idx, 2'b00};
  endfunction : ra

  task automatic rdc(input logic [PSDR_AW-1:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic ok;
    host_u.xfer(a, 1'b1, 32'h0, d, ok);
    chk({31'h0, ok}, 32'h1);
    chk(d, exp);
  endtask : rdc

  task automatic wrc(input logic [PSDR_AW-1:0] a, input logic [31:0] wd);
    logic [31:0] d;
    logic ok;
    host_u.xfer(a, 1'b0, wd, d, ok);
    chk({31'h0, ok}, 32'h1);
  endtask : wrc

  task automatic fn_sel(input int p, input logic [3:0] code);
    pin[p].fn_code <= code;
    pin[p].fn_wr <= 1'b1;
    tick(1);
    pin[p].fn_wr <= 1'b0;
    tick(1);
  endtask : fn_sel

  function automatic logic [31:0] st1(input int p, input logic done);
    return {24'h0, pin[p].disc_fail, done, pin[p].pwr_class, pin[p].fault_code};
  endfunction : st1

  function automatic logic [31:0] st2(input int p, input logic busy);
    return {27'h0, pin[p].wdog_active, busy, pin[p].fn_state};
  endfunction : st2

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    for (int p = 0; p < PSDR_NPORT; p++) begin
      for (int i = 4; i < 8; i++) begin
        rdc(ra(p, 4'(i)), 32'h0);
      end
    end
    rdc(9'h104, 32'h0);
  endtask : t_reset

  task automatic t_fields();
    for (int k = 0; k < 6; k++) begin
      for (int p = 0; p < PSDR_NPORT; p++) begin
        pin[p].disc_fail <= k[0];
        pin[p].pwr_class <= 3'(k % 5);
        pin[p].fault_code <= 3'((k + p) % 5);
        pin[p].wdog_active <= k[1];
        pin[p].fn_state <= 3'(k);
      end
      tick(2);
      for (int p = 0; p < PSDR_NPORT; p++) begin
        rdc(ra(p, IDX_STAT1), st1(p, 1'b0));
        rdc(ra(p, IDX_STAT2), st2(p, 1'b0));
      end
    end
    // Out-of-range codes keep the last legal value
    pin[1].pwr_class <= 3'h5;
    pin[1].fault_code <= 3'h7;
    pin[1].fn_state <= 3'h6;
    tick(2);
    rdc(ra(1, IDX_STAT1), 32'h81);
    rdc(ra(1, IDX_STAT2), 32'h05);
  endtask : t_fields

  task automatic t_disc(input int p, input logic [3:0] code,
                        input logic [14:0] prev, input logic [14:0] res);
    fn_sel(p, code);
    rdc(ra(p, IDX_DHIGH), {24'h0, 1'b0, prev[14:8]});
    pin[p].adc_start <= 1'b1;
    tick(1);
    pin[p].adc_start <= 1'b0;
    tick(1);
    rdc(ra(p, IDX_STAT2), st2(p, 1'b1));
    pin[p].adc_result <= res;
    pin[p].adc_done <= 1'b1;
    tick(1);
    pin[p].adc_done <= 1'b0;
    tick(2);
    rdc(ra(p, IDX_STAT2), st2(p, 1'b0));
    rdc(ra(p, IDX_DLOW), {24'h0, res[7:0]});
    rdc(ra(p, IDX_DHIGH), {24'h0, 1'b1, res[14:8]});
  endtask : t_disc

  task automatic t_done(input int p);
    pin[p].fn_done <= 1'b1;
    tick(1);
    pin[p].fn_done <= 1'b0;
    tick(2);
    rdc(ra(p, IDX_STAT1), st1(p, 1'b1));
    fn_sel(p, 4'h3);
    rdc(ra(p, IDX_STAT1), st1(p, 1'b0));
  endtask : t_done

  task automatic t_ro();
    for (int i = 4; i < 8; i++) begin
      wrc(ra(3, 4'(i)), 32'hFF);
    end
    rdc(ra(3, IDX_DLOW), 32'h23);
    rdc(ra(3, IDX_DHIGH), 32'h81);
    rdc(ra(3, IDX_DHIGH), 32'h81);
    rdc(ra(3, IDX_STAT1), st1(3, 1'b0));
    rdc(9'h108, 32'h0);
  endtask : t_ro

  task automatic t_irq();
    rdc(9'h100, 32'h94);
    wrc(9'h104, 32'h01);
    rdc(9'h104, 32'h01);
    chk({31'h0, irq}, 32'h0);
    pin[0].fn_done <= 1'b1;
    tick(1);
    pin[0].fn_done <= 1'b0;
    tick(3);
    chk({31'h0, irq}, 32'h1);
    rdc(9'h100, 32'h01);
    tick(2);
    chk({31'h0, irq}, 32'h0);
    wrc(9'h104, 32'h00);
    fn_sel(0, 4'h3);
    pin[0].fn_done <= 1'b1;
    tick(1);
    pin[0].fn_done <= 1'b0;
    tick(3);
    chk({31'h0, irq}, 32'h0);
    rdc(9'h100, 32'h01);
  endtask : t_irq

  task automatic tally_and_finish();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : tally_and_finish

  // ==========================================================
  // Clock, watchdog and main sequence
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // Whole run needs a few hundred cycles; this leaves ample margin
  initial begin
    #(20 * 20000);
    mismatches++;
    tally_and_finish();
  end

  initial begin
    mismatches = 0;
    checked = 0;
    srst <= 1'b1;
    for (int p = 0; p < PSDR_NPORT; p++) begin
      pin[p] <= '0;
    end
    tick(12);
    srst <= 1'b0;
    tick(1);
    t_reset();
    t_fields();
    t_disc(0, FN_DISC1, 15'h0, 15'h5A3C);
    t_disc(0, FN_DISC2, 15'h5A3C, 15'h7FFF);
    t_disc(3, FN_DISC2, 15'h0, 15'h0123);
    t_done(2);
    t_ro();
    t_irq();
    tally_and_finish();
  end
endmodule : port_status_discovery_results_tb

`default_nettype wire
